// File: pcr_config_regs.v
// Notes on behaviour
// - sixteen-bit internal link to VCO subsystem
// - link clocked by calibration clock, rate field
// - each indirect write forwarded MSB first
// - packet: target, sub-register, nine data bits
// - calibration overwrites only the data field
// - reset packet: tune off, caps, core select
// - address zero reads fixed identity value
// - address zero write sets open-mode read pointer
// - bit five of address zero soft-resets port
// - bit zero picks pin or software enable
// - bit one is software enable, resets high
// - bits two to seven hold blocks powered
`timescale 1ns/10ps
`include "pcr_regs.vh"

module pcr_config_regs #(
  parameter [23:0] IDENT_VALUE = 24'h5A0C31  // arbitrary value, not a real part code
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // register port from the serial front end
  input  wire        regWrEn,
  input  wire        regRdEn,
  input  wire [4:0]  regAddr,
  input  wire [23:0] regWrData,
  output wire        regWrReady,
  output reg  [23:0] regRdData_q,
  // open-mode read-back word for the next serial cycle
  input  wire        openMode,
  output reg  [23:0] openRdData_q,
  output reg         softResetPulse_q,
  // calibration machine access to the data field
  input  wire        calWrEn,
  input  wire [8:0]  calWrData,
  output wire        calWrReady,
  // link rate code from the calibration settings
  input  wire [1:0]  linkRateSel,
  // internal vco link
  output reg         vcoLinkClk_q,
  output reg         vcoLinkData_q,
  output reg         vcoLinkFrame_q,
  output wire        vcoLinkBusy,
  // enable control
  input  wire        extEnablePin,
  output wire        synthEnable,
  output wire        biasOn,
  output wire        phaseDetOn,
  output wire        chargePumpOn,
  output wire        refBufferOn,
  output wire        divBufferOn,
  output wire        gpoDriverOn
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  localparam [1:0] LS_IDLE  = 2'b00;
  localparam [1:0] LS_LOW   = 2'b01;
  localparam [1:0] LS_HIGH  = 2'b10;

  reg [`PCR_RPTR_MSB:0]    readPtr_q;
  reg [`PCR_ENCTL_W-1:0]   enCtl_q;
  reg [`PCR_IND_W-1:0]     indirect_q;
  reg                      pend_q;
  reg [`PCR_IND_W-1:0]     shift_q;
  reg [3:0]                bitCnt_q;
  reg [1:0]                linkSt_q;
  reg [7:0]                divCnt_q;

  wire wrIdent;
  wire wrEnCtl;
  wire wrInd;
  wire calTake;
  wire tick;
  wire [7:0] halfPeriod;

  // ------------------------------------------------------------
  // shared register read mux
  // ------------------------------------------------------------
  function [23:0] regValue;
    input [4:0] a;
    begin
      case (a)
        `PCR_ADDR_IDENT:    regValue = IDENT_VALUE;
        `PCR_ADDR_ENCTL:    regValue = {14'h0000, enCtl_q};
        `PCR_ADDR_INDIRECT: regValue = {8'h00, indirect_q};
        default:            regValue = 24'h000000;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // write decode and back-pressure
  // ------------------------------------------------------------
  // a queued packet holds the indirect register until the link
  // takes it, so a newer write waits instead of clobbering it
  assign regWrReady = !(regAddr == `PCR_ADDR_INDIRECT && pend_q);
  assign calWrReady = !pend_q;
  assign wrIdent    = regWrEn && regAddr == `PCR_ADDR_IDENT;
  assign wrEnCtl    = regWrEn && regAddr == `PCR_ADDR_ENCTL;
  assign wrInd      = regWrEn && regWrReady && regAddr == `PCR_ADDR_INDIRECT;
  assign calTake    = calWrEn && !pend_q && !wrInd;

  // ------------------------------------------------------------
  // address zero: read pointer and soft reset
  // ------------------------------------------------------------
  // identity is a constant, so a write here never reaches it
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      readPtr_q        <= 5'h00;
      softResetPulse_q <= 1'b0;
    end else begin
      softResetPulse_q <= wrIdent && regWrData[`PCR_SOFTRST_BIT];
      if (wrIdent && regWrData[`PCR_SOFTRST_BIT]) begin
        readPtr_q <= 5'h00;
      end else if (wrIdent && openMode) begin
        readPtr_q <= regWrData[`PCR_RPTR_MSB:0];
      end
    end
  end

  // ------------------------------------------------------------
  // read data: direct read and open-mode pointer read
  // ------------------------------------------------------------
  // the open-mode word is re-sampled every cycle so the next
  // serial cycle always shifts out current contents
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData_q  <= 24'h000000;
      openRdData_q <= 24'h000000;
    end else begin
      if (regRdEn) begin
        regRdData_q <= regValue(regAddr);
      end
      openRdData_q <= regValue(readPtr_q);
    end
  end

  // ------------------------------------------------------------
  // enable control register
  // ------------------------------------------------------------
  // reserved bits 9:8 are stored and read back, nothing uses them
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enCtl_q <= `PCR_ENCTL_RST;
    end else if (wrEnCtl) begin
      enCtl_q <= regWrData[`PCR_ENCTL_W-1:0];
    end
  end

  // enable source select and per-block keep-alive overrides
  assign synthEnable  = enCtl_q[`PCR_EN_PINSEL_BIT] ? extEnablePin
                                                    : enCtl_q[`PCR_EN_SOFT_BIT];
  assign biasOn       = synthEnable | enCtl_q[2];
  assign phaseDetOn   = synthEnable | enCtl_q[3];
  assign chargePumpOn = synthEnable | enCtl_q[4];
  assign refBufferOn  = synthEnable | enCtl_q[5];
  assign divBufferOn  = synthEnable | enCtl_q[6];
  assign gpoDriverOn  = synthEnable | enCtl_q[`PCR_HOLD_MSB];

  // ------------------------------------------------------------
  // indirect register and forwarding request
  // ------------------------------------------------------------
  // calibration only replaces the data field; target and
  // sub-register keep what the host last wrote
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      indirect_q <= `PCR_IND_RST;
      pend_q     <= 1'b0;
    end else begin
      if (wrInd) begin
        indirect_q <= regWrData[`PCR_IND_W-1:0];
      end else if (calTake) begin
        indirect_q[`PCR_DATA_MSB:`PCR_DATA_LSB] <= calWrData;
      end
      // a new request wins over the link taking the old one
      if (wrInd || calTake) begin
        pend_q <= 1'b1;
      end else if (linkSt_q == LS_IDLE) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // link bit-rate divider
  // ------------------------------------------------------------
  // half period is 2^code core cycles; at the core rate used
  // here even code 0 stays below the calibration clock limit
  assign halfPeriod = 8'h01 << linkRateSel;
  assign tick       = (divCnt_q == halfPeriod - 8'h01);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_q <= 8'h00;
    end else if (linkSt_q == LS_IDLE || tick) begin
      divCnt_q <= 8'h00;
    end else begin
      divCnt_q <= divCnt_q + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // internal vco link shifter
  // ------------------------------------------------------------
  // data changes while the clock is low and is sampled by the
  // subsystem on the rising edge; sixteen bits, MSB first
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      linkSt_q       <= LS_IDLE;
      shift_q        <= 16'h0000;
      bitCnt_q       <= 4'h0;
      vcoLinkClk_q   <= 1'b0;
      vcoLinkData_q  <= 1'b0;
      vcoLinkFrame_q <= 1'b0;
    end else begin
      case (linkSt_q)
        LS_IDLE: begin
          vcoLinkClk_q <= 1'b0;
          if (pend_q) begin
            shift_q        <= indirect_q;
            vcoLinkData_q  <= indirect_q[`PCR_IND_W-1];
            vcoLinkFrame_q <= 1'b1;
            bitCnt_q       <= 4'h0;
            linkSt_q       <= LS_LOW;
          end
        end
        LS_LOW: begin
          if (tick) begin
            vcoLinkClk_q <= 1'b1;
            linkSt_q     <= LS_HIGH;
          end
        end
        LS_HIGH: begin
          if (tick) begin
            vcoLinkClk_q <= 1'b0;
            if (bitCnt_q == `PCR_LAST_BIT) begin
              vcoLinkFrame_q <= 1'b0;
              vcoLinkData_q  <= 1'b0;
              linkSt_q       <= LS_IDLE;
            end else begin
              shift_q       <= {shift_q[`PCR_IND_W-2:0], 1'b0};
              vcoLinkData_q <= shift_q[`PCR_IND_W-2];
              bitCnt_q      <= bitCnt_q + 4'h1;
              linkSt_q      <= LS_LOW;
            end
          end
        end
        default: begin
          linkSt_q <= LS_IDLE;
        end
      endcase
    end
  end

  assign vcoLinkBusy = (linkSt_q != LS_IDLE) || pend_q;

endmodule

// File: pcr_config_regs_assertions.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module pcr_cfg_chk #(
  parameter [23:0] IDENT_VALUE = 24'h5A0C31  // arbitrary value
) (
  // clock and reset
  input wire        core_clk,
  input wire        rstn,
  // register port
  input wire        regWrEn,
  input wire        regRdEn,
  input wire [4:0]  regAddr,
  input wire [23:0] regWrData,
  input wire        regWrReady,
  input wire [23:0] regRdData_q,
  input wire        openMode,
  input wire [23:0] openRdData_q,
  input wire        softResetPulse_q,
  input wire        calWrReady,
  // link and enables
  input wire        vcoLinkClk_q,
  input wire        vcoLinkData_q,
  input wire        vcoLinkFrame_q,
  input wire        extEnablePin,
  input wire        synthEnable,
  input wire        biasOn,
  input wire        phaseDetOn,
  input wire        chargePumpOn,
  input wire        refBufferOn,
  input wire        divBufferOn,
  input wire        gpoDriverOn
);
  reg        clkPrev_q;
  reg  [4:0] bitCnt_q;
  wire       w0     = regWrEn && regAddr == 5'h00;
  wire       w1     = regWrEn && regAddr == 5'h01;
  wire [5:0] holdOn = {gpoDriverOn, divBufferOn, refBufferOn, chargePumpOn, phaseDetOn, biasOn};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // link clock rises in the open frame; a short or long frame shows at its end
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clkPrev_q <= 1'b0;
      bitCnt_q <= 5'h00;
    end else begin
      clkPrev_q <= vcoLinkClk_q;
      if (!vcoLinkFrame_q) bitCnt_q <= 5'h00;
      else if (vcoLinkClk_q && !clkPrev_q) bitCnt_q <= bitCnt_q + 5'h01;
    end
  end
  a_enable_source: assert property (w1 |=> synthEnable ==
    ($past(regWrData[0]) ? extEnablePin : $past(regWrData[1]))) else $error("enable source wrong");
  a_hold_blocks: assert property (w1 |=> holdOn ==
    ({6{synthEnable}} | $past(regWrData[7:2]))) else $error("block hold wrong");
  a_ident_read: assert property (regRdEn && regAddr == 5'h00 |=> regRdData_q == IDENT_VALUE)
    else $error("identity read wrong");
  a_soft_pulse: assert property (w0 && regWrData[5] |=> softResetPulse_q ##1 !softResetPulse_q)
    else $error("soft reset pulse wrong");
  a_pointer_load: assert property (w0 && openMode && regWrData[5:0] == 6'h00
    |=> ##1 openRdData_q == IDENT_VALUE) else $error("read pointer wrong");
  a_queue_stall: assert property (!calWrReady && regAddr == 5'h05 |-> !regWrReady)
    else $error("queued write not stalled");
  a_frame_start: assert property (regWrEn && regAddr == 5'h05 && regWrReady && calWrReady
    && !vcoLinkFrame_q |=> ##1 vcoLinkFrame_q && !vcoLinkClk_q) else $error("frame late");
  a_idle_clock: assert property (!vcoLinkFrame_q |-> !vcoLinkClk_q) else $error("link clock idle");
  a_data_edge: assert property (!$stable(vcoLinkData_q) && vcoLinkFrame_q && $past(vcoLinkFrame_q)
    |-> $fell(vcoLinkClk_q)) else $error("link data off edge");
  a_bit_count: assert property ($fell(vcoLinkFrame_q) |-> bitCnt_q == 5'h10)
    else $error("packet length wrong");
  c_packet: cover property ($fell(vcoLinkFrame_q));
  c_soft: cover property (softResetPulse_q);
  c_stall: cover property (!calWrReady && regWrEn && regAddr == 5'h05);
endmodule

bind pcr_config_regs pcr_cfg_chk #(.IDENT_VALUE(IDENT_VALUE)) pcr_cfg_chk_i (.*);

// File: pcr_link_rx.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// vco link receiver model
// ------------------------------------------------------------
module pcr_link_rx (
  // internal vco link
  input  wire        linkClk,
  input  wire        linkData,
  input  wire        linkFrame,
  // last closed-frame packet and packet count
  output reg  [15:0] pkt,
  output reg  [7:0]  nPkt
);
  reg [15:0] sh;
  initial begin
    pkt = 16'h0000;
    nPkt = 8'h00;
    sh = 16'h0000;
  end
  // sample on the rising link clock, where data has settled
  always @(posedge linkClk) if (linkFrame) sh <= {sh[14:0], linkData};
  // a packet counts once its frame closes; a cut frame is taken too, with whatever bits it shifted in
  always @(negedge linkFrame) begin
    pkt <= sh;
    nPkt <= nPkt + 8'h01;
  end
endmodule

// File: pcr_regs.vh
`ifndef PCR_REGS_VH
`define PCR_REGS_VH

// ------------------------------------------------------------
// register addresses (5-bit space)
// ------------------------------------------------------------
`define PCR_ADDR_IDENT      5'h00
`define PCR_ADDR_ENCTL      5'h01
`define PCR_ADDR_INDIRECT   5'h05

// ------------------------------------------------------------
// read pointer / soft reset write fields
// ------------------------------------------------------------
`define PCR_RPTR_MSB        4
`define PCR_SOFTRST_BIT     5

// ------------------------------------------------------------
// enable control fields and reset value
// ------------------------------------------------------------
`define PCR_ENCTL_W         10
`define PCR_ENCTL_RST       10'h002
`define PCR_EN_PINSEL_BIT   0
`define PCR_EN_SOFT_BIT     1
`define PCR_HOLD_LSB        2
`define PCR_HOLD_MSB        7

// ------------------------------------------------------------
// indirect register fields
// ------------------------------------------------------------
`define PCR_IND_W           16
`define PCR_IND_RST         16'h0000
`define PCR_TGT_MSB         2
`define PCR_SUBREG_LSB      3
`define PCR_SUBREG_MSB      6
`define PCR_DATA_LSB        7
`define PCR_DATA_MSB        15

// ------------------------------------------------------------
// link timing
// ------------------------------------------------------------
`define PCR_CORE_CLK_MHZ    10
`define PCR_FSM_MAX_MHZ     50
`define PCR_LAST_BIT        4'hF

`endif

// File: testbench.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// testbench
// ------------------------------------------------------------
module testbench;
  localparam [23:0] IDENT = 24'h3C96E1;  // arbitrary value
  reg         core_clk = 1'b0;
  reg         rstn = 1'b0;
  reg         regWrEn = 1'b0;
  reg         regRdEn = 1'b0;
  reg  [4:0]  regAddr = 5'h00;
  reg  [23:0] regWrData = 24'h000000;
  reg         openMode = 1'b0;
  reg         calWrEn = 1'b0;
  reg  [8:0]  calWrData = 9'h000;
  reg  [1:0]  linkRateSel = 2'h0;
  reg         extEnablePin = 1'b0;
  wire        regWrReady, softResetPulse_q, calWrReady, vcoLinkClk_q, vcoLinkData_q, vcoLinkFrame_q;
  wire        vcoLinkBusy, synthEnable, biasOn, phaseDetOn, chargePumpOn, refBufferOn, divBufferOn;
  wire        gpoDriverOn;
  wire [23:0] regRdData_q, openRdData_q;
  wire [15:0] pkt;
  wire [7:0]  nPkt;
  wire [6:0]  ens = {gpoDriverOn, divBufferOn, refBufferOn, chargePumpOn, phaseDetOn, biasOn, synthEnable};
  int         mismatches = 0;
  int         n_tests = 0;
  int         cyc = 0;
  pcr_config_regs #(.IDENT_VALUE(IDENT)) pcr_config_regs_i (.*);
  pcr_link_rx pcr_link_rx_i (.linkClk(vcoLinkClk_q), .linkData(vcoLinkData_q), .linkFrame(vcoLinkFrame_q),
                             .pkt(pkt), .nPkt(nPkt));
  always #50 core_clk = ~core_clk;
  // hang guard: the whole run needs about seven hundred cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict;
    end
  end
  task chk(input logic [23:0] s, input logic [23:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // write held until ready is seen high at a taking edge
  task wr(input [4:0] a, input [23:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    #1;
    while (regWrReady !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    regWrEn = 1'b0;
  endtask
  task rd(input [4:0] a, input [23:0] e);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    @(negedge core_clk);
    chk(regRdData_q, e);
  endtask
  task wait_pkt(input [7:0] n);
    while (nPkt !== n) @(negedge core_clk);
  endtask
  task t_enable;
    chk(ens, 7'h7F);
    rd(5'h01, 24'h000002);
    wr(5'h01, 24'h000300);
    chk(ens, 7'h00);
    rd(5'h01, 24'h000300);
    wr(5'h01, 24'h000001);
    chk(synthEnable, 1'b0);
    extEnablePin = 1'b1;
    #1 chk(synthEnable, 1'b1);
    for (int i = 2; i < 8; i++) begin
      wr(5'h01, 24'h000001 << i);
      chk(ens, 7'h02 << (i - 2));
    end
  endtask
  task t_pointer;
    wr(5'h00, 24'h000001);
    rd(5'h00, IDENT);
    chk(openRdData_q, IDENT);
    openMode = 1'b1;
    wr(5'h00, 24'h000000);
    @(negedge core_clk);
    chk(openRdData_q, IDENT);
    wr(5'h00, 24'h000001);
    @(negedge core_clk);
    chk(openRdData_q, 24'h000080);
    wr(5'h00, 24'h000020);
    chk(softResetPulse_q, 1'b1);
    @(negedge core_clk);
    chk({softResetPulse_q, openRdData_q}, {1'b0, IDENT});
  endtask
  // each rate code: one packet, its length and its bits
  task t_rates;
    int k;
    for (int c = 0; c < 4; c++) begin
      linkRateSel = c;
      k = 0;
      wr(5'h05, 24'h007F10);
      while (!vcoLinkFrame_q) @(negedge core_clk);
      while (vcoLinkFrame_q) begin
        k++;
        @(negedge core_clk);
      end
      chk(k, 32 << c);
      chk(pkt, 16'h7F10);
    end
    rd(5'h05, 24'h007F10);
  endtask
  // three writes back to back: the third waits for the link
  task t_queue;
    int n;
    n = nPkt;
    linkRateSel = 2'h0;
    wr(5'h05, 24'h00AD00);
    wr(5'h05, 24'h007F10);
    wr(5'h05, 24'h008000);
    chk(pkt, 16'hAD00);
    wait_pkt(n + 2);
    chk(pkt, 16'h7F10);
    wait_pkt(n + 3);
    chk(pkt, 16'h8000);
    calWrData = 9'h1A5;
    calWrEn = 1'b1;
    #1;
    while (calWrReady !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    calWrEn = 1'b0;
    wait_pkt(n + 4);
    chk(pkt, 16'hD280);
    rd(5'h05, 24'h00D280);
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    t_enable;
    t_pointer;
    t_rates;
    t_queue;
    print_verdict;
  end
endmodule
